// [hw/hbl_top.sv]
// Headset button classification and headphone load test control with Wishbone registers
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "hbl_defines.svh"
module hbl_top
  import hbl_pkg::*;
#(
  parameter int GAP_CYC = `HBL_GAP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire hbl_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Jack detection results
  input wire logic det_four_i,
  input wire logic det_voice_first_i,
  // Coarse one-bit measurement
  output logic coarse_req_o,
  input wire logic coarse_vld_i,
  input wire logic coarse_hit_i,
  // Eight-bit ADC measurement
  output logic adc_req_o,
  input wire logic adc_vld_i,
  input wire logic [7:0] adc_code_i,
  // Headphone load test
  input wire logic hp_below_i,
  output logic hp_test_en_o,
  output logic [1:0] hp_limit_sel_o,
  // Plug configuration
  output logic plug_four_o,
  output logic order_voice_first_o,
  // Button result
  output hbl_res_t button_o,
  output logic button_vld_o
);
  typedef enum logic [2:0] {
    HBL_IDLE,
    HBL_C_REQ,
    HBL_C_WAIT,
    HBL_A_GAP,
    HBL_A_WAIT,
    HBL_DONE
  } hbl_state_t;

  localparam int GAP_W = $clog2(GAP_CYC + 1);

  initial begin
    if (GAP_CYC < 1 || GAP_CYC > 1048575) $error("hbl_top GAP_CYC out of range");
  end

  function automatic logic [3:0] hbl_rep_count(input logic [1:0] sel);
    return 4'h1 << sel;
  endfunction : hbl_rep_count

  // Registers
  hbl_split_t split_q;
  logic type_force_q;
  logic order_force_q;
  logic [1:0] coarse_rep_q;
  logic [1:0] avg_sel_q;
  logic [1:0] hp_sel_q;
  logic hp_en_q;
  logic [2:0] ctrl_q;
  logic res_new_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic hp_meta_q;
  logic hp_sync_q;

  // Bus decode
  logic [`HBL_IDX_W-1:0] idx;
  logic bus_req;
  logic wr_lane;
  logic rd_en;
  logic wr_split_low;
  logic wr_split_mid;
  logic wr_split_upper;
  logic wr_split_mic;
  logic wr_plug;
  logic wr_hp;
  logic wr_ctrl;
  logic wr_res;
  logic [7:0] wd;
  logic [31:0] rd_mux;
  logic [7:0] rd_plug;
  logic [7:0] rd_hp;
  logic hp_cmp;

  assign idx = wb_req_i.adr[`HBL_ADR_W-1:`HBL_IDX_LSB];
  assign bus_req = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  // Write lands on the edge at which the master samples ack
  assign wr_lane = wb_req_i.cyc & wb_req_i.stb & ack_q & wb_req_i.we & wb_req_i.sel[0];
  assign rd_en = bus_req & ~wb_req_i.we;
  assign wd = wb_req_i.dat[7:0];
  assign wr_split_low = wr_lane & (idx == `HBL_IDX_SPLIT_LOW);
  assign wr_split_mid = wr_lane & (idx == `HBL_IDX_SPLIT_MID);
  assign wr_split_upper = wr_lane & (idx == `HBL_IDX_SPLIT_UPPER);
  assign wr_split_mic = wr_lane & (idx == `HBL_IDX_SPLIT_MIC);
  assign wr_plug = wr_lane & (idx == `HBL_IDX_PLUG);
  assign wr_hp = wr_lane & (idx == `HBL_IDX_HPTEST);
  assign wr_ctrl = wr_lane & (idx == `HBL_IDX_CTRL);
  assign wr_res = wr_lane & (idx == `HBL_IDX_RESULT);

  // Comparator reads zero while the test block is switched off
  assign hp_cmp = hp_sync_q & hp_en_q;
  assign rd_plug = {2'h0, type_force_q, order_force_q, coarse_rep_q, avg_sel_q};
  assign rd_hp = {3'h0, hp_cmp, 1'b0, hp_sel_q, hp_en_q};
  assign rd_mux =
      (idx == `HBL_IDX_SPLIT_LOW) ? {24'h0, split_q.split_low} :
      (idx == `HBL_IDX_SPLIT_MID) ? {24'h0, split_q.split_mid} :
      (idx == `HBL_IDX_SPLIT_UPPER) ? {24'h0, split_q.split_upper} :
      (idx == `HBL_IDX_SPLIT_MIC) ? {24'h0, split_q.split_mic} :
      (idx == `HBL_IDX_PLUG) ? {24'h0, rd_plug} :
      (idx == `HBL_IDX_HPTEST) ? {24'h0, rd_hp} :
      (idx == `HBL_IDX_CTRL) ? {29'h0, ctrl_q} :
      (idx == `HBL_IDX_RESULT) ? {16'h0, button_o.code, 4'h0, res_new_q, button_o.btn} :
      32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= bus_req;
      if (rd_en) begin
        dat_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      split_q.split_low <= `HBL_RST_SPLIT_LOW;
      split_q.split_mid <= `HBL_RST_SPLIT_MID;
      split_q.split_upper <= `HBL_RST_SPLIT_UPPER;
      split_q.split_mic <= `HBL_RST_SPLIT_MIC;
      type_force_q <= 1'b0;
      order_force_q <= 1'b0;
      coarse_rep_q <= `HBL_RST_COARSE;
      avg_sel_q <= `HBL_RST_AVG;
      hp_sel_q <= `HBL_RST_HP_SEL;
      hp_en_q <= 1'b0;
      ctrl_q <= `HBL_RST_CTRL;
    end else begin
      if (wr_split_low) begin
        split_q.split_low <= wd;
      end
      if (wr_split_mid) begin
        split_q.split_mid <= wd;
      end
      if (wr_split_upper) begin
        split_q.split_upper <= wd;
      end
      if (wr_split_mic) begin
        split_q.split_mic <= wd;
      end
      if (wr_plug) begin
        type_force_q <= wd[`HBL_BIT_TYPE_FORCE];
        order_force_q <= wd[`HBL_BIT_ORDER_FORCE];
        coarse_rep_q <= wd[`HBL_COARSE_HI:`HBL_COARSE_LO];
        avg_sel_q <= wd[`HBL_AVG_HI:`HBL_AVG_LO];
      end
      if (wr_hp) begin
        hp_sel_q <= wd[`HBL_HP_SEL_HI:`HBL_HP_SEL_LO];
        hp_en_q <= wd[`HBL_BIT_HP_EN];
      end
      if (wr_ctrl) begin
        ctrl_q <= wd[`HBL_BIT_MEAS_EN:`HBL_BIT_TYPE_AUTO];
      end
    end
  end

  // Analog comparator is asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hp_meta_q <= 1'b0;
      hp_sync_q <= 1'b0;
    end else begin
      hp_meta_q <= hp_below_i;
      hp_sync_q <= hp_meta_q;
    end
  end

  // Measurement sequencer
  hbl_state_t state_q;
  hbl_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [GAP_W-1:0] gap_q;
  logic [GAP_W-1:0] gap_d;
  logic [3:0] coarse_need;
  logic [3:0] avg_need;
  logic gap_done;
  logic avg_clr;
  logic avg_add;
  logic [7:0] avg_mean;
  logic done;

  assign coarse_need = hbl_rep_count(coarse_rep_q);
  assign avg_need = hbl_rep_count(avg_sel_q);
  assign gap_done = (gap_q == GAP_W'(GAP_CYC - 1));
  assign avg_clr = (state_q == HBL_IDLE);
  assign avg_add = (state_q == HBL_A_WAIT) & adc_vld_i;
  assign done = (state_q == HBL_DONE);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    gap_d = '0;
    unique case (state_q)
      HBL_IDLE: begin
        cnt_d = 4'h0;
        if (ctrl_q[`HBL_BIT_MEAS_EN]) begin
          state_d = HBL_C_REQ;
        end
      end
      HBL_C_REQ: begin
        state_d = HBL_C_WAIT;
      end
      HBL_C_WAIT: begin
        if (coarse_vld_i) begin
          if (!coarse_hit_i) begin
            state_d = HBL_IDLE;
          end else if (cnt_q + 4'h1 == coarse_need) begin
            cnt_d = 4'h0;
            state_d = HBL_A_GAP;
          end else begin
            cnt_d = cnt_q + 4'h1;
            state_d = HBL_C_REQ;
          end
        end
      end
      HBL_A_GAP: begin
        // One settling gap before every sample
        gap_d = gap_q + GAP_W'(1);
        if (gap_done) begin
          gap_d = '0;
          state_d = HBL_A_WAIT;
        end
      end
      HBL_A_WAIT: begin
        if (adc_vld_i) begin
          cnt_d = cnt_q + 4'h1;
          state_d = (cnt_q + 4'h1 == avg_need) ? HBL_DONE : HBL_A_GAP;
        end
      end
      HBL_DONE: begin
        state_d = HBL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= HBL_IDLE;
      cnt_q <= 4'h0;
      gap_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      gap_q <= gap_d;
    end
  end

  hbl_avg #(
    .W(8),
    .LOG_MAX(3)
  ) u_avg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(avg_clr),
    .add_i(avg_add),
    .sample_i(adc_code_i),
    .shift_i(avg_sel_q),
    .mean_o(avg_mean)
  );

  // Output flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      coarse_req_o <= 1'b0;
      adc_req_o <= 1'b0;
      button_o <= '{btn: HBL_BTN_VOICE, code: 8'h00};
      button_vld_o <= 1'b0;
      res_new_q <= 1'b0;
      plug_four_o <= 1'b0;
      order_voice_first_o <= 1'b0;
      hp_test_en_o <= 1'b0;
      hp_limit_sel_o <= `HBL_RST_HP_SEL;
    end else begin
      coarse_req_o <= (state_d == HBL_C_REQ);
      adc_req_o <= (state_q == HBL_A_GAP) & gap_done;
      button_vld_o <= done;
      if (done) begin
        button_o <= '{btn: hbl_classify(avg_mean, split_q), code: avg_mean};
      end
      // A new result beats a clear in the same cycle
      res_new_q <= done | (res_new_q & ~(wr_res & wd[`HBL_BIT_RES_NEW]));
      plug_four_o <= ctrl_q[`HBL_BIT_TYPE_AUTO] ? det_four_i : type_force_q;
      order_voice_first_o <= ctrl_q[`HBL_BIT_ORDER_AUTO] ? det_voice_first_i : order_force_q;
      hp_test_en_o <= hp_en_q;
      hp_limit_sel_o <= hp_sel_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Helper counters for the checks
  logic [3:0] chk_adc_n;
  logic [3:0] chk_coarse_n;
  logic [GAP_W:0] chk_gap;
  always_ff @(posedge clk_i) begin
    if (rst_i || avg_clr) begin
      chk_adc_n <= 4'h0;
      chk_coarse_n <= 4'h0;
    end else begin
      chk_adc_n <= chk_adc_n + {3'h0, adc_req_o};
      chk_coarse_n <= chk_coarse_n + {3'h0, coarse_req_o};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || adc_req_o || state_q != HBL_A_GAP) begin
      chk_gap <= '0;
    end else begin
      chk_gap <= chk_gap + (GAP_W + 1)'(1);
    end
  end

  property p_split_reset;
    @(posedge clk_i) $fell(rst_i) |-> split_q.split_low == `HBL_RST_SPLIT_LOW &&
      split_q.split_mid == `HBL_RST_SPLIT_MID && split_q.split_upper == `HBL_RST_SPLIT_UPPER &&
      split_q.split_mic == `HBL_RST_SPLIT_MIC;
  endproperty
  a_split_reset: assert property (p_split_reset) else $error("limit reset value wrong");

  property p_classify;
    @(posedge clk_i) disable iff (rst_i)
      button_vld_o |-> button_o.btn == hbl_classify(button_o.code, split_q);
  endproperty
  a_classify: assert property (p_classify) else $error("button class wrong");

  property p_coarse_count;
    @(posedge clk_i) disable iff (rst_i)
      adc_req_o |-> chk_coarse_n == coarse_need;
  endproperty
  a_coarse_count: assert property (p_coarse_count) else $error("coarse repeat count wrong");

  property p_avg_count;
    @(posedge clk_i) disable iff (rst_i)
      button_vld_o |-> chk_adc_n == avg_need;
  endproperty
  a_avg_count: assert property (p_avg_count) else $error("sample count wrong");

  property p_gap;
    @(posedge clk_i) disable iff (rst_i)
      adc_req_o |-> $past(chk_gap) == (GAP_W + 1)'(GAP_CYC - 1);
  endproperty
  a_gap: assert property (p_gap) else $error("sample gap wrong");

  property p_plug_force;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_q[`HBL_BIT_TYPE_AUTO] && $stable(type_force_q) |=> plug_four_o == $past(type_force_q);
  endproperty
  a_plug_force: assert property (p_plug_force) else $error("forced plug type ignored");

  property p_order_force;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_q[`HBL_BIT_ORDER_AUTO] |=> order_voice_first_o == $past(order_force_q);
  endproperty
  a_order_force: assert property (p_order_force) else $error("forced order ignored");

  property p_hp_read;
    @(posedge clk_i) disable iff (rst_i)
      rd_en && idx == `HBL_IDX_HPTEST |=> wb_dat_o[`HBL_BIT_HP_CMP] == $past(hp_cmp);
  endproperty
  a_hp_read: assert property (p_hp_read) else $error("load comparator read wrong");

  property p_hp_ctrl;
    @(posedge clk_i) disable iff (rst_i)
      wr_hp ##2 !$past(wr_hp) |-> hp_limit_sel_o == $past(wd[`HBL_HP_SEL_HI:`HBL_HP_SEL_LO], 2) &&
        hp_test_en_o == $past(wd[`HBL_BIT_HP_EN], 2);
  endproperty
  a_hp_ctrl: assert property (p_hp_ctrl) else $error("load test control not applied");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

  property p_cv_button;
    @(posedge clk_i) disable iff (rst_i) button_vld_o && button_o.btn != HBL_BTN_VOICE;
  endproperty
  c_button: cover property (p_cv_button);

  property p_cv_abort;
    @(posedge clk_i) disable iff (rst_i) state_q == HBL_C_WAIT && coarse_vld_i && !coarse_hit_i;
  endproperty
  c_abort: cover property (p_cv_abort);

  property p_cv_avg8;
    @(posedge clk_i) disable iff (rst_i) button_vld_o && avg_sel_q == 2'h3;
  endproperty
  c_avg8: cover property (p_cv_avg8);
endmodule : hbl_top
`default_nettype wire

// [hw/hbl_defines.svh]
// Offsets, field positions, reset values and timing of the headset button and load test block
`ifndef HBL_DEFINES_SVH
`define HBL_DEFINES_SVH

`define HBL_ADR_W 12
`define HBL_IDX_W 10
`define HBL_IDX_LSB 2

`define HBL_IDX_SPLIT_LOW 10'h0c8
`define HBL_IDX_SPLIT_MID 10'h0c9
`define HBL_IDX_SPLIT_UPPER 10'h0ca
`define HBL_IDX_SPLIT_MIC 10'h0cb
`define HBL_IDX_PLUG 10'h0cc
`define HBL_IDX_HPTEST 10'h0cd
`define HBL_IDX_CTRL 10'h0ce
`define HBL_IDX_RESULT 10'h0cf

`define HBL_RST_SPLIT_LOW 8'h0a
`define HBL_RST_SPLIT_MID 8'h16
`define HBL_RST_SPLIT_UPPER 8'h21
`define HBL_RST_SPLIT_MIC 8'h3e
`define HBL_RST_COARSE 2'h0
`define HBL_RST_AVG 2'h1
`define HBL_RST_HP_SEL 2'h1
`define HBL_RST_CTRL 3'h3

`define HBL_BIT_TYPE_FORCE 5
`define HBL_BIT_ORDER_FORCE 4
`define HBL_COARSE_HI 3
`define HBL_COARSE_LO 2
`define HBL_AVG_HI 1
`define HBL_AVG_LO 0
`define HBL_BIT_HP_CMP 4
`define HBL_HP_SEL_HI 2
`define HBL_HP_SEL_LO 1
`define HBL_BIT_HP_EN 0
`define HBL_BIT_TYPE_AUTO 0
`define HBL_BIT_ORDER_AUTO 1
`define HBL_BIT_MEAS_EN 2
`define HBL_RES_CLS_HI 2
`define HBL_RES_CLS_LO 0
`define HBL_BIT_RES_NEW 3
`define HBL_RES_CODE_HI 15
`define HBL_RES_CODE_LO 8

`define HBL_GAP_US 1000
`define HBL_CLK_MHZ 20
`define HBL_GAP_CYC (`HBL_GAP_US * `HBL_CLK_MHZ)

`endif

// [hw/hbl_pkg.sv]
// Types and classification function of the headset button and load test block
`include "hbl_defines.svh"

package hbl_pkg;

  typedef enum logic [2:0] {
    HBL_BTN_LOWEST,
    HBL_BTN_SECOND,
    HBL_BTN_THIRD,
    HBL_BTN_FOURTH,
    HBL_BTN_VOICE
  } hbl_btn_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [`HBL_ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } hbl_wb_req_t;

  typedef struct packed {
    logic [7:0] split_low;
    logic [7:0] split_mid;
    logic [7:0] split_upper;
    logic [7:0] split_mic;
  } hbl_split_t;

  typedef struct packed {
    hbl_btn_t btn;
    logic [7:0] code;
  } hbl_res_t;

  // First limit above the code names the button, else the voice contact
  function automatic hbl_btn_t hbl_classify(input logic [7:0] code, input hbl_split_t s);
    hbl_btn_t b;
    b = HBL_BTN_VOICE;
    if (code < s.split_low) begin
      b = HBL_BTN_LOWEST;
    end else if (code < s.split_mid) begin
      b = HBL_BTN_SECOND;
    end else if (code < s.split_upper) begin
      b = HBL_BTN_THIRD;
    end else if (code < s.split_mic) begin
      b = HBL_BTN_FOURTH;
    end
    return b;
  endfunction : hbl_classify

endpackage : hbl_pkg

// [hw/hbl_avg.sv]
// Running sum and power-of-two mean of 8-bit button samples
`timescale 1ns/100ps
`default_nettype none
module hbl_avg #(
  parameter int W = 8,
  parameter int LOG_MAX = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sample stream
  input wire logic clr_i,
  input wire logic add_i,
  input wire logic [W-1:0] sample_i,
  input wire logic [1:0] shift_i,
  // Sum of the samples added since the last clear, shifted right by shift_i; updated at each add
  output logic [W-1:0] mean_o
);
  logic [W+LOG_MAX-1:0] acc_q;
  logic [W+LOG_MAX-1:0] acc_d;
  logic [W+LOG_MAX-1:0] acc_sum;
  logic [W+LOG_MAX-1:0] acc_shr;

  initial begin
    if (LOG_MAX < 3) $error("hbl_avg needs room for eight samples");
  end

  assign acc_sum = acc_q + {{LOG_MAX{1'b0}}, sample_i};
  assign acc_d = clr_i ? '0 : (add_i ? acc_sum : acc_q);
  assign acc_shr = acc_sum >> shift_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '0;
      mean_o <= '0;
    end else begin
      acc_q <= acc_d;
      if (add_i) begin
        mean_o <= acc_shr[W-1:0];
      end
    end
  end
endmodule : hbl_avg
`default_nettype wire

// [dv/hbl_acc_model.sv]
// Plugged-in headset model answering measurement requests and the load comparator
`timescale 1ns/100ps
`default_nettype none
module hbl_acc_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Scenario controls
  input wire logic hit_i,
  input wire logic [7:0] base_i,
  input wire logic [3:0] dly_i,
  input wire logic [15:0] load_i,
  // Measurement requests and answers
  input wire logic coarse_req_i,
  output logic coarse_vld_o,
  output logic coarse_hit_o,
  input wire logic adc_req_i,
  output logic adc_vld_o,
  output logic [7:0] adc_code_o,
  // Load comparator
  input wire logic [1:0] lim_sel_i,
  output logic hp_below_o
);
  logic [4:0] cc_q;
  logic [4:0] ac_q;
  logic [2:0] n_q;
  logic [15:0] lim;
  assign lim = lim_sel_i == 2'h0 ? 16'h03e8 : lim_sel_i == 2'h1 ? 16'h09c4 :
               lim_sel_i == 2'h2 ? 16'h1388 : 16'h2710;
  assign hp_below_o = load_i < lim;
  initial begin
    coarse_vld_o = 1'b0;
    coarse_hit_o = 1'b0;
    adc_vld_o = 1'b0;
    adc_code_o = 8'h00;
  end
  always @(posedge clk_i) begin
    coarse_vld_o <= 1'b0;
    adc_vld_o <= 1'b0;
    // Idle lines keep moving so a stale value is never mistaken for an answer
    coarse_hit_o <= ~coarse_hit_o;
    adc_code_o <= ~adc_code_o;
    if (rst_i) begin
      cc_q <= 5'h00;
      ac_q <= 5'h00;
      n_q <= 3'h0;
    end else begin
      cc_q <= coarse_req_i ? {1'b0, dly_i} + 5'h01 : (cc_q != 5'h00 ? cc_q - 5'h01 : 5'h00);
      ac_q <= adc_req_i ? {1'b0, dly_i} + 5'h01 : (ac_q != 5'h00 ? ac_q - 5'h01 : 5'h00);
      if (coarse_req_i) begin
        n_q <= 3'h0;
      end
      if (cc_q == 5'h01) begin
        coarse_vld_o <= 1'b1;
        coarse_hit_o <= hit_i;
      end
      if (ac_q == 5'h01) begin
        adc_vld_o <= 1'b1;
        adc_code_o <= base_i + {5'h00, n_q};
        n_q <= n_q + 3'h1;
      end
    end
  end
endmodule : hbl_acc_model
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench of the headset button and load test block
`timescale 1ns/100ps
`default_nettype none
module tb import hbl_pkg::*;;
  localparam int G = 4;
  logic clk_i, rst_i, wb_ack_o, det_four_i, det_voice_first_i, hit, run;
  logic coarse_req_o, coarse_vld_i, coarse_hit_i, adc_req_o, adc_vld_i, hp_below_i;
  logic hp_test_en_o, plug_four_o, order_voice_first_o, button_vld_o;
  logic [31:0] wb_dat_o, rd;
  logic [7:0] adc_code_i, base, m;
  logic [1:0] hp_limit_sel_o;
  logic [3:0] dly;
  logic [15:0] load, rs;
  logic [7:0] lims [4];
  logic [7:0] rtab [7] = '{8'h0a, 8'h16, 8'h21, 8'h3e, 8'h01, 8'h02, 8'h03};
  logic [15:0] hpt [4] = '{16'h03e8, 16'h09c4, 16'h1388, 16'h2710};
  hbl_wb_req_t req;
  hbl_res_t button_o;
  int fails, compares, nc, na, ncyc, cyc, z;

  hbl_top #(.GAP_CYC(G)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .det_four_i(det_four_i),
    .det_voice_first_i(det_voice_first_i), .coarse_req_o(coarse_req_o),
    .coarse_vld_i(coarse_vld_i), .coarse_hit_i(coarse_hit_i), .adc_req_o(adc_req_o),
    .adc_vld_i(adc_vld_i), .adc_code_i(adc_code_i), .hp_below_i(hp_below_i),
    .hp_test_en_o(hp_test_en_o), .hp_limit_sel_o(hp_limit_sel_o),
    .plug_four_o(plug_four_o), .order_voice_first_o(order_voice_first_o),
    .button_o(button_o), .button_vld_o(button_vld_o));

  hbl_acc_model u_acc (.clk_i(clk_i), .rst_i(rst_i), .hit_i(hit), .base_i(base),
    .dly_i(dly), .load_i(load), .coarse_req_i(coarse_req_o), .coarse_vld_o(coarse_vld_i),
    .coarse_hit_o(coarse_hit_i), .adc_req_i(adc_req_o), .adc_vld_o(adc_vld_i),
    .adc_code_o(adc_code_i), .lim_sel_i(hp_limit_sel_o), .hp_below_o(hp_below_i));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [7:0] exp_mean(input logic [7:0] b, input logic [1:0] a);
    logic [10:0] s;
    s = 11'h000;
    for (int k = 0; k < (1 << a); k++) begin
      s = s + {3'h0, b} + 11'(k);
    end
    return 8'(s >> a);
  endfunction : exp_mean

  function automatic logic [2:0] exp_cls(input logic [7:0] c);
    for (int k = 0; k < 4; k++) begin
      if (c < lims[k]) begin
        return 3'(k);
      end
    end
    return 3'h4;
  endfunction : exp_cls

  task automatic give_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled high
  task automatic bus(input logic we, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, wd}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    r = wb_dat_o;
    req <= '0;
    if (n >= 50) begin
      chk("ack", 32'h1, 32'h0);
    end
  endtask : bus

  task automatic meas(input logic [1:0] rep, input logic [1:0] avg, input logic h,
                      input logic [7:0] b);
    int n;
    n = 0;
    rs = lfsr(rs);
    dly <= rs[3:0];
    hit <= h;
    base <= b;
    bus(1'b1, 10'h0cc, {4'h0, rep, avg}, rd);
    nc = 0;
    na = 0;
    ncyc = 0;
    run = 1'b1;
    bus(1'b1, 10'h0ce, 8'h07, rd);
    // Enable is looked at only in idle, so exactly one pass runs
    bus(1'b1, 10'h0ce, 8'h03, rd);
    do begin
      @(posedge clk_i);
      n++;
    end while (button_vld_o !== 1'b1 && n < 1500);
    repeat (40) @(posedge clk_i);
    run = 1'b0;
    if (h) begin
      m = exp_mean(b, avg);
      chk("done", 32'h1, {31'h0, n < 1500});
      chk("coarse count", 32'(1 << rep), 32'(nc));
      chk("sample count", 32'(1 << avg), 32'(na));
      chk("latency", 32'h1, {31'h0, ncyc >= (1 << avg) * G});
      chk("code", {24'h0, m}, {24'h0, button_o.code});
      chk("class", {29'h0, exp_cls(m)}, {29'h0, button_o.btn});
      bus(1'b0, 10'h0cf, 8'h00, rd);
      chk("result", {16'h0, m, 4'h0, 1'b1, exp_cls(m)}, rd);
      bus(1'b1, 10'h0cf, 8'h08, rd);
      bus(1'b0, 10'h0cf, 8'h00, rd);
      chk("result cleared", {16'h0, m, 4'h0, 1'b0, exp_cls(m)}, rd);
    end else begin
      chk("aborted", 32'h0, 32'(na));
      chk("aborted coarse", 32'h1, 32'(nc));
    end
  endtask : meas

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      give_verdict;
    end
    if (run) begin
      nc += int'(coarse_req_o);
      na += int'(adc_req_o);
      ncyc++;
      if (button_vld_o === 1'b1) begin
        run = 1'b0;
      end
    end
  end

  initial begin
    req = '0;
    rst_i = 1'b1;
    det_four_i = 1'b0;
    det_voice_first_i = 1'b0;
    hit = 1'b1;
    base = 8'h00;
    dly = 4'h0;
    load = 16'h0000;
    run = 1'b0;
    rs = 16'hf7e6;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 10'h0c8 + i[9:0], 8'h00, rd);
      chk("reset value", {24'h0, rtab[i]}, rd);
    end
    bus(1'b1, 10'h3ff, 8'h5a, rd);
    bus(1'b0, 10'h3ff, 8'h00, rd);
    chk("unmapped", 32'h0, rd);
    z = 0;
    for (int k = 0; k < 4; k++) begin
      rs = lfsr(rs);
      z = z + 50 + int'(rs[7:0]);
      lims[k] = 8'((256 * z) / (z + 2200));
      bus(1'b1, 10'h0c8 + k[9:0], lims[k], rd);
      bus(1'b0, 10'h0c8 + k[9:0], 8'h00, rd);
      chk("limit", {24'h0, lims[k]}, rd);
    end
    bus(1'b1, 10'h0ce, 8'h00, rd);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 10'h0cc, {2'h0, i[1:0], 4'h0}, rd);
      repeat (2) @(posedge clk_i);
      chk("forced type", {31'h0, i[1]}, {31'h0, plug_four_o});
      chk("forced order", {31'h0, i[0]}, {31'h0, order_voice_first_o});
    end
    bus(1'b1, 10'h0ce, 8'h03, rd);
    for (int i = 0; i < 4; i++) begin
      rs = lfsr(rs);
      det_four_i <= rs[0];
      det_voice_first_i <= rs[1];
      repeat (3) @(posedge clk_i);
      chk("auto type", {31'h0, rs[0]}, {31'h0, plug_four_o});
      chk("auto order", {31'h0, rs[1]}, {31'h0, order_voice_first_o});
    end
    for (int i = 0; i < 8; i++) begin
      rs = lfsr(rs);
      load <= {2'h0, rs[13:0]};
      bus(1'b1, 10'h0cd, {3'h0, 1'b1, 1'b0, i[2:0]}, rd);
      repeat (4) @(posedge clk_i);
      chk("limit select", {30'h0, i[2:1]}, {30'h0, hp_limit_sel_o});
      chk("test enable", {31'h0, i[0]}, {31'h0, hp_test_en_o});
      bus(1'b0, 10'h0cd, 8'h00, rd);
      chk("comparator", {27'h0, ({2'h0, rs[13:0]} < hpt[i[2:1]]) & i[0], 1'b0, i[2:0]}, rd);
    end
    for (int i = 0; i < 4; i++) begin
      rs = lfsr(rs);
      meas(i[1:0], 2'(3 - i), 1'b1, i == 2 ? lims[1] : {1'b0, rs[6:0]});
    end
    meas(2'h0, 2'h3, 1'b1, 8'hf0);
    meas(2'h1, 2'h0, 1'b0, 8'h10);
    give_verdict;
  end
endmodule : tb
`default_nettype wire
